// ===== readback_margin_consts.vh
/*
  constants for the readback scheduler and margining control: register
  offsets, field positions, reset values and timing counts.
  assumes inclusion by bare name from the design file.
*/
`ifndef READBACK_MARGIN_CONSTS_VH
`define READBACK_MARGIN_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (8-bit address)
// ----------------------------------------------------------------
`define RM_CTRL_ADDR 8'h00
`define RM_CHSEL_ADDR 8'h01
`define RM_LIMTYPE_ADDR 8'h02
`define RM_STATUS_ADDR 8'h03
`define RM_MASK_ADDR 8'h04
`define RM_WARN_ADDR 8'h05
`define RM_MENABLE_ADDR 8'h06
`define RM_RESULT_BASE 8'h10
`define RM_LIMIT_BASE 8'h20
`define RM_CODE_BASE 8'h30
`define RM_ULIM_BASE 8'h38
`define RM_LLIM_BASE 8'h40
`define RM_OFFSEL_BASE 8'h48

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define RM_CTRL_GO_BIT 0
`define RM_CTRL_CONT_BIT 1
`define RM_CTRL_AVG_BIT 2
`define RM_CTRL_STOP_BIT 3

// status fields
`define RM_ST_DONE_BIT 0
`define RM_ST_WARN_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RM_CODE_RESET 8'h7F
`define RM_ULIM_RESET 8'hFF
`define RM_LLIM_RESET 8'h00
`define RM_MIDCODE 8'h7F

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RM_CONV_TIME_NS 500000
`define RM_CLK_PERIOD_NS 40
`define RM_CONV_CYCLES (`RM_CONV_TIME_NS / `RM_CLK_PERIOD_NS)
`define RM_TRACK_CYCLES 5'h10
`define RM_AVG_PASSES 16

`endif

// ===== supply_readback_and_margining.v
/*
  round robin readback scheduler with per-channel limit warnings, and six
  margining code channels with limit clipping and glitch-free enable.
  assumes a same-clock register port and converter handshake; the
  sequencing engine start request arrives from logic on the same clock.
*/
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "readback_margin_consts.vh"

// Function
// - convert any chosen subset of 10 channels in fixed loop order.
// - loop runs once and stops, or repeats forever, by configuration.
// - averaging runs the full loop 16 times before any result.
// - results commit only after the whole cycle, averaging included.
// - results are 12-bit unsigned, zero to 4095 at reference.
// - one limit per channel, acting as minimum or maximum only.
// - crossing the limit sets a readable warning that feeds sequencing.
// - start by host write or by sequencing engine state request.
// - each selected channel takes about 500 us to convert.
// - six margining outputs, each with its own code register.
// - output linear in code, offset voltage at code 0x7F.
// - each output selects one of four midcode offsets.
// - 256 codes: 128 up and 127 down around midcode.
// - on enable, buffer tracks pin first, then drives converter value.
// - applied code is written code clamped between lower and upper limits.
// - lower limit above upper limit keeps that output high impedance.
module supply_readback_and_margining #(
  parameter NUM_CH = 10,
  parameter NUM_DAC = 6,
  parameter CONV_CYCLES = `RM_CONV_CYCLES
) (
  // clock and reset
  input wire clk_sys_in,
  input wire arst_n_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // analog converter sample (12-bit code of the current channel)
  input wire [11:0] adc_code_in,
  output reg [3:0] adc_mux_sel_out,
  output reg adc_busy_out,
  // sequencing engine
  input wire seq_start_in,
  output wire [NUM_CH-1:0] seq_warn_out,
  // margining outputs
  output wire [8*NUM_DAC-1:0] margin_code_out,
  output wire [2*NUM_DAC-1:0] margin_offset_sel_out,
  output wire [NUM_DAC-1:0] margin_track_out,
  output wire [NUM_DAC-1:0] margin_drive_out,
  // interrupt
  output wire irq_out
);

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_NEXT = 2'b10;
  localparam ST_COMMIT = 2'b11;
  // slot length cut to the timer width on purpose
  localparam integer CONV_LAST_FULL = CONV_CYCLES - 1;
  localparam [19:0] CONV_LAST = CONV_LAST_FULL[19:0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg cont_q;
  reg avg_q;
  reg [NUM_CH-1:0] chsel_q;
  reg [NUM_CH-1:0] limtype_q; // 1 = limit is a maximum
  reg [1:0] status_q;
  reg [1:0] mask_q;
  reg [NUM_CH-1:0] warn_q;
  reg [NUM_DAC-1:0] menable_q;
  reg [11:0] result_q [0:NUM_CH-1];
  reg [11:0] limit_q [0:NUM_CH-1];
  reg [15:0] acc_q [0:NUM_CH-1];
  reg [7:0] code_q [0:NUM_DAC-1];
  reg [7:0] ulim_q [0:NUM_DAC-1];
  reg [7:0] llim_q [0:NUM_DAC-1];
  reg [1:0] offsel_q [0:NUM_DAC-1];
  reg [4:0] track_cnt_q [0:NUM_DAC-1];
  reg [1:0] state_q;
  reg [3:0] ch_q;
  reg [3:0] pass_q;
  reg [19:0] tmr_q;
  reg seq_start_prev_q;

  // ----------------------------------------------------------------
  // decode and scheduler helpers
  // ----------------------------------------------------------------
  wire ctrl_wr = reg_wr_in && (reg_addr_in == `RM_CTRL_ADDR);
  wire host_go = ctrl_wr && reg_wdata_in[`RM_CTRL_GO_BIT];
  wire host_stop = ctrl_wr && reg_wdata_in[`RM_CTRL_STOP_BIT];
  wire seq_go = seq_start_in && !seq_start_prev_q; // rising request only
  wire start_req = (host_go || seq_go) && (chsel_q != {NUM_CH{1'b0}});
  wire [3:0] last_pass = avg_q ? 4'hF : 4'h0;

  // first selected channel at or after a position; fixed ascending order
  function [4:0] next_sel;
    input [NUM_CH-1:0] sel;
    input [4:0] from;
    integer i;
    reg found;
    begin
      found = 1'b0;
      next_sel = 5'h1F;
      for (i = 0; i < NUM_CH; i = i + 1) begin
        if (!found && (i >= from) && sel[i]) begin
          found = 1'b1;
          next_sel = i[4:0];
        end
      end
    end
  endfunction

  wire [4:0] first_ch = next_sel(chsel_q, 5'h00);
  wire [4:0] follow_ch = next_sel(chsel_q, {1'b0, ch_q} + 5'h01);

  // ----------------------------------------------------------------
  // round robin scheduler
  // ----------------------------------------------------------------
  wire done_evt = (state_q == ST_COMMIT);
  integer k;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
      ch_q <= 4'h0;
      pass_q <= 4'h0;
      tmr_q <= 20'h00000;
      seq_start_prev_q <= 1'b0;
      adc_busy_out <= 1'b0;
      adc_mux_sel_out <= 4'h0;
      for (k = 0; k < NUM_CH; k = k + 1) begin
        acc_q[k] <= 16'h0000;
        result_q[k] <= 12'h000;
      end
    end else begin
      seq_start_prev_q <= seq_start_in;
      case (state_q)
        ST_IDLE: begin
          adc_busy_out <= 1'b0;
          if (start_req) begin
            state_q <= ST_CONV;
            ch_q <= first_ch[3:0];
            adc_mux_sel_out <= first_ch[3:0];
            pass_q <= 4'h0;
            tmr_q <= 20'h00000;
            adc_busy_out <= 1'b1;
            for (k = 0; k < NUM_CH; k = k + 1) begin
              acc_q[k] <= 16'h0000;
            end
          end
        end
        ST_CONV: begin
          // one fixed conversion slot per selected channel
          if (tmr_q == CONV_LAST) begin
            acc_q[ch_q] <= acc_q[ch_q] + {4'h0, adc_code_in};
            state_q <= ST_NEXT;
          end else begin
            tmr_q <= tmr_q + 20'h00001;
          end
        end
        ST_NEXT: begin
          tmr_q <= 20'h00000;
          if (follow_ch != 5'h1F) begin
            ch_q <= follow_ch[3:0];
            adc_mux_sel_out <= follow_ch[3:0];
            state_q <= ST_CONV;
          end else if (pass_q != last_pass) begin
            pass_q <= pass_q + 4'h1;
            ch_q <= first_ch[3:0];
            adc_mux_sel_out <= first_ch[3:0];
            state_q <= ST_CONV;
          end else begin
            state_q <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          // averaged sum of 16 passes divided down; single pass as is
          for (k = 0; k < NUM_CH; k = k + 1) begin
            if (chsel_q[k]) begin
              result_q[k] <= avg_q ? acc_q[k][15:4] : acc_q[k][11:0];
            end
            acc_q[k] <= 16'h0000;
          end
          pass_q <= 4'h0;
          if (cont_q && (first_ch != 5'h1F)) begin
            ch_q <= first_ch[3:0];
            adc_mux_sel_out <= first_ch[3:0];
            state_q <= ST_CONV;
          end else begin
            state_q <= ST_IDLE;
            adc_busy_out <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (host_stop) begin
        state_q <= ST_IDLE;
        adc_busy_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // limit compare, per channel warning (live, follows latest result)
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_warn
      always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          warn_q[g] <= 1'b0;
        end else if (!chsel_q[g]) begin
          warn_q[g] <= 1'b0;
        end else begin
          // one limit only; its type picks the direction of the test
          warn_q[g] <= limtype_q[g] ? (result_q[g] > limit_q[g]) : (result_q[g] < limit_q[g]);
        end
      end
    end
  endgenerate
  assign seq_warn_out = warn_q;

  // ----------------------------------------------------------------
  // margining channels: clamp, tri-state and glitch-free enable
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NUM_DAC; g = g + 1) begin : g_dac
      wire bad_lim = llim_q[g] > ulim_q[g];
      wire [7:0] clip = (code_q[g] < llim_q[g]) ? llim_q[g] :
                        ((code_q[g] > ulim_q[g]) ? ulim_q[g] : code_q[g]);
      wire on = menable_q[g] && !bad_lim;
      // code travels unsigned 8-bit; the analog side scales around 0x7F
      assign margin_code_out[8*g +: 8] = clip;
      assign margin_offset_sel_out[2*g +: 2] = offsel_q[g];
      assign margin_track_out[g] = on && (track_cnt_q[g] != `RM_TRACK_CYCLES);
      assign margin_drive_out[g] = on && (track_cnt_q[g] == `RM_TRACK_CYCLES);
      // buffer follows the pin for a settling window before it drives
      always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          track_cnt_q[g] <= 5'h00;
        end else if (!on) begin
          track_cnt_q[g] <= 5'h00;
        end else if (track_cnt_q[g] != `RM_TRACK_CYCLES) begin
          track_cnt_q[g] <= track_cnt_q[g] + 5'h01;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes, sticky status (set wins over clear)
  // ----------------------------------------------------------------
  wire warn_any = |warn_q;
  integer kr; // loop index owned by this process alone
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cont_q <= 1'b0;
      avg_q <= 1'b0;
      chsel_q <= {NUM_CH{1'b0}};
      limtype_q <= {NUM_CH{1'b0}};
      status_q <= 2'b00;
      mask_q <= 2'b00;
      menable_q <= {NUM_DAC{1'b0}};
      for (kr = 0; kr < NUM_CH; kr = kr + 1) begin
        limit_q[kr] <= 12'h000;
      end
      for (kr = 0; kr < NUM_DAC; kr = kr + 1) begin
        code_q[kr] <= `RM_CODE_RESET;
        ulim_q[kr] <= `RM_ULIM_RESET;
        llim_q[kr] <= `RM_LLIM_RESET;
        offsel_q[kr] <= 2'b00;
      end
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `RM_CTRL_ADDR: begin
            cont_q <= reg_wdata_in[`RM_CTRL_CONT_BIT];
            avg_q <= reg_wdata_in[`RM_CTRL_AVG_BIT];
          end
          `RM_CHSEL_ADDR: chsel_q <= reg_wdata_in[NUM_CH-1:0];
          `RM_LIMTYPE_ADDR: limtype_q <= reg_wdata_in[NUM_CH-1:0];
          `RM_STATUS_ADDR: status_q <= status_q & ~reg_wdata_in[1:0];
          `RM_MASK_ADDR: mask_q <= reg_wdata_in[1:0];
          `RM_MENABLE_ADDR: menable_q <= reg_wdata_in[NUM_DAC-1:0];
          default: begin
            for (kr = 0; kr < NUM_CH; kr = kr + 1) begin
              if (reg_addr_in == `RM_LIMIT_BASE + kr[7:0]) limit_q[kr] <= reg_wdata_in[11:0];
            end
            for (kr = 0; kr < NUM_DAC; kr = kr + 1) begin
              if (reg_addr_in == `RM_CODE_BASE + kr[7:0]) code_q[kr] <= reg_wdata_in[7:0];
              if (reg_addr_in == `RM_ULIM_BASE + kr[7:0]) ulim_q[kr] <= reg_wdata_in[7:0];
              if (reg_addr_in == `RM_LLIM_BASE + kr[7:0]) llim_q[kr] <= reg_wdata_in[7:0];
              if (reg_addr_in == `RM_OFFSEL_BASE + kr[7:0]) offsel_q[kr] <= reg_wdata_in[1:0];
            end
          end
        endcase
      end
      // events set after the clear so a same-cycle event is kept
      if (done_evt) status_q[`RM_ST_DONE_BIT] <= 1'b1;
      if (warn_any) status_q[`RM_ST_WARN_BIT] <= 1'b1;
    end
  end
  assign irq_out = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe; unmapped reads zero
  // ----------------------------------------------------------------
  reg [15:0] rd_d;
  integer kd; // loop index owned by the read mux
  always @* begin
    rd_d = 16'h0000;
    kd = 0;
    case (reg_addr_in)
      `RM_CTRL_ADDR: rd_d = {12'h000, 1'b0, avg_q, cont_q, adc_busy_out};
      `RM_CHSEL_ADDR: rd_d[NUM_CH-1:0] = chsel_q;
      `RM_LIMTYPE_ADDR: rd_d[NUM_CH-1:0] = limtype_q;
      `RM_STATUS_ADDR: rd_d[1:0] = status_q;
      `RM_MASK_ADDR: rd_d[1:0] = mask_q;
      `RM_WARN_ADDR: rd_d[NUM_CH-1:0] = warn_q;
      `RM_MENABLE_ADDR: rd_d[NUM_DAC-1:0] = menable_q;
      default: begin
        for (kd = 0; kd < NUM_CH; kd = kd + 1) begin
          if (reg_addr_in == `RM_RESULT_BASE + kd[7:0]) rd_d = {4'h0, result_q[kd]};
          if (reg_addr_in == `RM_LIMIT_BASE + kd[7:0]) rd_d = {4'h0, limit_q[kd]};
        end
        for (kd = 0; kd < NUM_DAC; kd = kd + 1) begin
          if (reg_addr_in == `RM_CODE_BASE + kd[7:0]) rd_d = {8'h00, code_q[kd]};
          if (reg_addr_in == `RM_ULIM_BASE + kd[7:0]) rd_d = {8'h00, ulim_q[kd]};
          if (reg_addr_in == `RM_LLIM_BASE + kd[7:0]) rd_d = {8'h00, llim_q[kd]};
          if (reg_addr_in == `RM_OFFSEL_BASE + kd[7:0]) rd_d = {14'h0000, offsel_q[kd]};
        end
      end
    endcase
  end

  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_d;
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule // supply_readback_and_margining

// ===== converter_model.sv
/*
  stand-in for the converter and the sequencing engine.
  assumes the block's clock; sample codes depend on the channel index.
*/
`timescale 1ns/1ns
module converter_model (
  // clock
  input wire clk_sys_in,
  // block side
  input wire [3:0] mux_sel_in,
  input wire busy_in,
  input wire state_on_in,
  output reg [11:0] code_out = 12'h5A5,
  output reg seq_start_out = 1'b0
);
  // a fixed code per channel while converting, a toggling pattern when
  // idle so that a sample taken outside a slot shows as a bad result
  always @(posedge clk_sys_in) begin
    if (busy_in) code_out <= (mux_sel_in == 4'h0) ? 12'h000 : (mux_sel_in == 4'h9) ? 12'hFFF : {mux_sel_in, 8'h3C};
    else code_out <= ~code_out;
    seq_start_out <= state_on_in;
  end
endmodule // converter_model

// ===== readback_margin_assertions.sv
/*
  assertion checker for the readback and margining block.
  assumes only the top ports; bound at the foot of this file.
*/
`timescale 1ns/1ns
`include "readback_margin_consts.vh"
module readback_margin_check #(
  parameter NUM_DAC = 6
) (
  // clock and reset
  input wire clk_sys_in,
  input wire arst_n_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire reg_rd_in,
  input wire reg_wr_in,
  input wire [15:0] reg_rdata_out,
  // scheduler and margining
  input wire [3:0] adc_mux_sel_out,
  input wire adc_busy_out,
  input wire seq_start_in,
  input wire [NUM_DAC-1:0] margin_track_out,
  input wire [NUM_DAC-1:0] margin_drive_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  reg [5:0] trk_q;
  // length of the tracking phase of output 0
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) trk_q <= 6'h00;
    else trk_q <= margin_track_out[0] ? trk_q + 6'h01 : 6'h00;
  end
  sequence new_slot;
    $changed(adc_mux_sel_out) && adc_busy_out;
  endsequence
  sequence handover;
    $rose(margin_drive_out[0]);
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside its cycle");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h7F |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  ctrl_busy_read_a: assert property (reg_rd_in && reg_addr_in == `RM_CTRL_ADDR |=> reg_rdata_out[0] == $past(adc_busy_out))
    else $error("busy bit read wrong");
  mux_range_a: assert property (adc_busy_out |-> adc_mux_sel_out < 4'hA)
    else $error("channel index out of range");
  slot_hold_a: assert property (new_slot |=> ($stable(adc_mux_sel_out) || !adc_busy_out)[*3])
    else $error("slot shorter than conversion");
  busy_start_a: assert property ($rose(adc_busy_out) |-> $past(reg_wr_in) || $past(seq_start_in) || $past(seq_start_in, 2))
    else $error("scheduler started without request");
  busy_hold_a: assert property ($rose(adc_busy_out) |=> adc_busy_out[*3])
    else $error("loop ended too early");
  track_window_a: assert property (handover |-> trk_q == 6'h10)
    else $error("tracking phase not 16 cycles");
  drive_excl_a: assert property ((margin_track_out & margin_drive_out) == 0)
    else $error("track and drive together");
endmodule // readback_margin_check
bind supply_readback_and_margining readback_margin_check #(.NUM_DAC(NUM_DAC)) chk (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out), .adc_mux_sel_out(adc_mux_sel_out),
  .adc_busy_out(adc_busy_out), .seq_start_in(seq_start_in), .margin_track_out(margin_track_out),
  .margin_drive_out(margin_drive_out));

// ===== supply_readback_and_margining_test.sv
/*
  self-checking bench for the readback and margining block.
  assumes the converter model feeds the sample and start inputs.
*/
`timescale 1ns/1ns
`include "readback_margin_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module supply_readback_and_margining_test;
  localparam int CV = 4;
  reg clk_sys_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0, rd = 1'b0, state_on = 1'b0;
  wire [15:0] rdata;
  wire [11:0] code, osel;
  wire [3:0] mux;
  wire busy, start, irq;
  wire [9:0] warn;
  wire [47:0] mcode;
  wire [5:0] trk, drv;
  int bad_count = 0;
  int n_tests = 0;
  int n, i, k;
  // short conversion slots keep the run brief
  supply_readback_and_margining #(.CONV_CYCLES(CV)) dut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .adc_code_in(code), .adc_mux_sel_out(mux),
    .adc_busy_out(busy), .seq_start_in(start), .seq_warn_out(warn), .margin_code_out(mcode),
    .margin_offset_sel_out(osel), .margin_track_out(trk), .margin_drive_out(drv), .irq_out(irq));
  converter_model model (.clk_sys_in(clk_sys_in), .mux_sel_in(mux), .busy_in(busy), .state_on_in(state_on),
    .code_out(code), .seq_start_out(start));
  always #20 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input [7:0] a, input [15:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic chk_reg(input [7:0] a, input [15:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_in);
  endtask
  // bounded wait for the scheduler to go idle, cycles counted in n
  task automatic wait_idle;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    if (n >= 2000) `CHK(busy, 1'b0)
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk_reg(`RM_CODE_BASE, 16'h007F);
    chk_reg(`RM_ULIM_BASE, 16'h00FF);
    chk_reg(`RM_LLIM_BASE, 16'h0000);
    chk_reg(8'h7F, 16'h0000);
    `CHK(mcode[7:0], 8'h7F)
    $display("reset values done");
  endtask
  // ch0 as minimum and ch9 as maximum, both crossed
  task automatic t_single;
    wr_reg(`RM_CHSEL_ADDR, 16'h0201);
    wr_reg(`RM_LIMTYPE_ADDR, 16'h0200);
    wr_reg(`RM_LIMIT_BASE + 8'h09, 16'h0FFE);
    wr_reg(`RM_LIMIT_BASE, 16'h0001);
    wr_reg(`RM_MASK_ADDR, 16'h0003);
    wr_reg(`RM_CTRL_ADDR, 16'h0001);
    #1 `CHK(mux, 4'h0)
    wait_idle;
    `CHK(n >= 2 * CV && n <= 2 * (CV + 1) + 4, 1'b1)
    tick(2);
    chk_reg(`RM_RESULT_BASE, 16'h0000);
    chk_reg(`RM_RESULT_BASE + 8'h09, 16'h0FFF);
    `CHK(warn, 10'h201)
    chk_reg(`RM_WARN_ADDR, 16'h0201);
    `CHK(irq, 1'b1)
    wr_reg(`RM_STATUS_ADDR, 16'h0003);
    chk_reg(`RM_STATUS_ADDR, 16'h0002);
    wr_reg(`RM_MASK_ADDR, 16'h0001);
    tick(1);
    #1 `CHK(irq, 1'b0)
    $display("single pass done");
  endtask
  task automatic t_avg;
    wr_reg(`RM_CHSEL_ADDR, 16'h0002);
    wr_reg(`RM_CTRL_ADDR, 16'h0005);
    tick(8 * (CV + 1));
    #1 `CHK(busy, 1'b1)
    chk_reg(`RM_RESULT_BASE + 8'h01, 16'h0000);
    wait_idle;
    `CHK(n >= 7 * (CV + 1), 1'b1)
    tick(2);
    chk_reg(`RM_RESULT_BASE + 8'h01, 16'h013C);
    $display("averaging done");
  endtask
  task automatic t_cont;
    logic [3:0] last;
    wr_reg(`RM_CHSEL_ADDR, 16'h0006);
    wr_reg(`RM_CTRL_ADDR, 16'h0003);
    #1 `CHK(mux, 4'h1)
    last = mux;
    for (i = 0; i < 4; i++) begin
      k = 0;
      while (mux === last && k < 3 * CV) begin
        @(posedge clk_sys_in);
        #1 k++;
      end
      `CHK(mux, (i % 2 == 0) ? 4'h2 : 4'h1)
      last = mux;
    end
    chk_reg(`RM_CTRL_ADDR, 16'h0003);
    wr_reg(`RM_CTRL_ADDR, 16'h0008);
    wait_idle;
    `CHK(n < 3, 1'b1)
    $display("continuous done");
  endtask
  task automatic t_seq;
    wr_reg(`RM_CHSEL_ADDR, 16'h0001);
    state_on <= 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 5) begin
      @(posedge clk_sys_in);
      #1 k++;
    end
    `CHK(busy, 1'b1)
    wait_idle;
    @(posedge clk_sys_in);
    state_on <= 1'b0;
    $display("engine start done");
  endtask
  task automatic t_margin;
    logic [7:0] cin [3] = '{8'hA0, 8'h50, 8'h70};
    logic [7:0] ce [3] = '{8'h90, 8'h60, 8'h70};
    for (i = 0; i < 4; i++) begin
      wr_reg(`RM_OFFSEL_BASE + i[7:0], i[15:0]);
      #1 `CHK(osel[2 * i +: 2], i[1:0])
    end
    wr_reg(`RM_ULIM_BASE, 16'h0090);
    wr_reg(`RM_LLIM_BASE, 16'h0060);
    for (i = 0; i < 3; i++) begin
      wr_reg(`RM_CODE_BASE, {8'h00, cin[i]});
      #1 `CHK(mcode[7:0], ce[i])
    end
    wr_reg(`RM_CODE_BASE + 8'h02, 16'h00FF);
    #1 `CHK(mcode[23:16], 8'hFF)
    wr_reg(`RM_CODE_BASE + 8'h02, 16'h0000);
    #1 `CHK(mcode[23:16], 8'h00)
    wr_reg(`RM_LLIM_BASE + 8'h01, 16'h0080);
    wr_reg(`RM_ULIM_BASE + 8'h01, 16'h0070);
    wr_reg(`RM_MENABLE_ADDR, 16'h0003);
    tick(1);
    #1 `CHK({trk[0], drv[0]}, 2'b10)
    tick(20);
    #1 `CHK({trk[0], drv[0]}, 2'b01)
    `CHK({trk[1], drv[1]}, 2'b00)
    // host side of the closed loop: read the code back, then nudge it
    chk_reg(`RM_CODE_BASE, 16'h0070);
    wr_reg(`RM_CODE_BASE, 16'h0078);
    #1 `CHK(mcode[7:0], 8'h78)
    $display("margining done");
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // the whole sequence needs well under a thousand cycles
  initial begin
    #(40 * 5000);
    bad_count++;
    $display("watchdog expired");
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_single;
    t_avg;
    t_cont;
    t_seq;
    t_margin;
    close_out;
  end
endmodule // supply_readback_and_margining_test
